// ### logic/loop_code_pkg.sv
// Purpose: Shared constants, register map and helpers for the loop code block.
// Assumes: Registers are word indexed; the byte address is four times the index.
// Notes:   Code lengths run from four to seven bits, code MSB on the line first.

package loop_code_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int IDX_W  = 10;
  localparam int REG_W  = 8;
  localparam int CODE_W = 7;
  localparam int LEN_W  = 3;
  localparam int SEL_W  = 2;

  // Word indices of the registers.
  localparam logic [IDX_W-1:0] IDX_LEN_CTRL   = 10'h12d;
  localparam logic [IDX_W-1:0] IDX_ACT_CODE   = 10'h12e;
  localparam logic [IDX_W-1:0] IDX_DEACT_CODE = 10'h12f;
  localparam logic [IDX_W-1:0] IDX_STATUS     = 10'h130;
  localparam logic [IDX_W-1:0] IDX_TX_CODE    = 10'h131;

  // Fields of the length control register.
  localparam int RXA_LEN_HI = 7;
  localparam int RXA_LEN_LO = 6;
  localparam int RXD_LEN_HI = 5;
  localparam int RXD_LEN_LO = 4;
  localparam int TX_LEN_HI  = 3;
  localparam int TX_LEN_LO  = 2;
  localparam int FRAMED_BIT = 1;
  localparam int AUTO_BIT   = 0;

  // Fields of the code registers: code value above, enable in bit zero.
  localparam int CODE_HI     = 7;
  localparam int CODE_LO     = 1;
  localparam int CODE_EN_BIT = 0;

  // Fields of the status register.
  localparam int STAT_LOOP_BIT  = 0;
  localparam int STAT_ACT_BIT   = 1;
  localparam int STAT_DEACT_BIT = 2;

  localparam logic [REG_W-1:0] LEN_CTRL_RST = 8'h00;
  localparam logic [REG_W-1:0] CODE_RST     = 8'haa;

  localparam logic [LEN_W-1:0] LEN_BASE = 3'h4;
  localparam logic [LEN_W-1:0] LEN_MAX  = 3'h7;
  localparam logic [LEN_W-1:0] CODE_MSB = 3'h6;
  localparam logic [LEN_W-1:0] LEN_ONE  = 3'h1;
  localparam logic [CODE_W-1:0] ALL_ONES = 7'h7f;

  typedef enum logic {
    LOOP_IDLE   = 1'b0,
    LOOP_ACTIVE = 1'b1
  } loop_state_t;

  // Number of code bits selected by a two-bit length field.
  function automatic logic [LEN_W-1:0] code_len(input logic [SEL_W-1:0] sel);
    code_len = LEN_BASE + {1'b0, sel};
  endfunction : code_len

  // Mask covering the newest n bits of a received window.
  function automatic logic [CODE_W-1:0] len_mask(input logic [LEN_W-1:0] n);
    len_mask = ALL_ONES >> (LEN_MAX - n);
  endfunction : len_mask

  // The first n bits of a code, moved down to line up with the window.
  function automatic logic [CODE_W-1:0] code_top(
    input logic [CODE_W-1:0] code,
    input logic [LEN_W-1:0]  n
  );
    code_top = code >> (LEN_MAX - n);
  endfunction : code_top

endpackage : loop_code_pkg

// ### logic/loop_code_detector.sv
// Purpose: Detects a repeating loop code of programmable length in a bit stream.
// Assumes: Bits arrive with a one-cycle valid strobe from same-clock logic.
// Notes:   Detection needs repeats_i aligned code periods in a row.

`timescale 1ns/1ps
`default_nettype none

module loop_code_detector #(
  parameter int CNT_W = 8
) (
  input  wire logic                              clock_i,
  input  wire logic                              rst_n_i,
  input  wire logic                              ce_i,
  input  wire logic                              enable_i,
  input  wire logic [loop_code_pkg::CODE_W-1:0]  code_i,
  input  wire logic [loop_code_pkg::SEL_W-1:0]   len_sel_i,
  input  wire logic                              bit_i,
  input  wire logic                              bit_valid_i,
  input  wire logic [CNT_W-1:0]                  repeats_i,
  output logic                                   detected_o
);

  logic [loop_code_pkg::CODE_W-1:0] window_r;
  logic [loop_code_pkg::CODE_W-1:0] window_nxt;
  logic [loop_code_pkg::LEN_W-1:0]  phase_r;
  logic [loop_code_pkg::LEN_W-1:0]  phase_nxt;
  logic [CNT_W-1:0]                 count_r;
  logic [CNT_W-1:0]                 count_nxt;
  logic                             locked_r;
  logic                             locked_nxt;
  logic                             det_r;
  logic                             det_nxt;
  logic [loop_code_pkg::CODE_W-1:0] window_new;
  logic [loop_code_pkg::LEN_W-1:0]  len;
  logic                             hit;

  always_comb begin
    window_new = {window_r[loop_code_pkg::CODE_W-2:0], bit_i};
    len        = loop_code_pkg::code_len(len_sel_i);
    hit        = (window_new & loop_code_pkg::len_mask(len)) ==
                 loop_code_pkg::code_top(code_i, len);
    window_nxt = window_r;
    phase_nxt  = phase_r;
    count_nxt  = count_r;
    locked_nxt = locked_r;
    if (!enable_i) begin
      window_nxt = '0;
      phase_nxt  = '0;
      count_nxt  = '0;
      locked_nxt = 1'b0;
    end else if (bit_valid_i) begin
      window_nxt = window_new;
      if (!locked_r) begin
        if (hit) begin
          locked_nxt = 1'b1;
          count_nxt  = CNT_W'(1);
          phase_nxt  = '0;
        end
      end else if (phase_r == len - loop_code_pkg::LEN_ONE) begin
        phase_nxt = '0;
        if (hit) begin
          count_nxt = (count_r == '1) ? count_r : count_r + CNT_W'(1);
        end else begin
          locked_nxt = 1'b0;
          count_nxt  = '0;
        end
      end else begin
        phase_nxt = phase_r + loop_code_pkg::LEN_ONE;
      end
    end
    det_nxt = locked_nxt && (count_nxt >= repeats_i);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      window_r <= '0;
      phase_r  <= '0;
      count_r  <= '0;
      locked_r <= 1'b0;
      det_r    <= 1'b0;
    end else if (ce_i) begin
      window_r <= window_nxt;
      phase_r  <= phase_nxt;
      count_r  <= count_nxt;
      locked_r <= locked_nxt;
      det_r    <= det_nxt;
    end
  end

  assign detected_o = det_r;

endmodule : loop_code_detector

`default_nettype wire

// ### logic/loop_code_control.sv
// Purpose: Loop code length control, code detection, code transmit and
//          automatic remote loopback, with an Avalon-MM register slave.
// Assumes: Line bits and transmit requests come from same-clock framer logic.
// Notes:   The bus answers every access after one wait cycle, plus one more for each cycle that ce_i is low.
//
// Chosen here: the Avalon-MM register port.

`timescale 1ns/1ps
`default_nettype none

// Function
// - Activation code length field 00..11 selects a 4 to 7 bit pattern.
// - Deactivation code length field 00..11 selects a 4 to 7 bit pattern.
// - Transmit loop code length field 00..11 gives 4 to 7 bit sequences.
// - Framed bit clear sends unframed code; set inserts code within framing.
// - Auto bit with activation detection enabled enters remote loopback on code.
// - Auto bit with deactivation detection enabled leaves remote loopback on code.
// - Activation code is seven bits, resets to 1010101, MSB received first.
// - Each detector runs only while its own enable bit is set.
module loop_code_control #(
  parameter int CNT_W   = 8,
  parameter int REPEATS = 16
) (
  input  wire logic                              clock_i,
  input  wire logic                              rstn_i,
  input  wire logic                              ce_i,
  input  wire logic [loop_code_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                              avs_read_i,
  input  wire logic                              avs_write_i,
  input  wire logic [loop_code_pkg::DATA_W-1:0]  avs_writedata_i,
  input  wire logic [loop_code_pkg::BE_W-1:0]    avs_byteenable_i,
  output logic      [loop_code_pkg::DATA_W-1:0]  avs_readdata_o,
  output logic                                   avs_waitrequest_o,
  input  wire logic                              rx_bit_i,
  input  wire logic                              rx_bit_valid_i,
  input  wire logic                              tx_bit_req_i,
  input  wire logic                              tx_frame_slot_i,
  output logic                                   tx_code_bit_o,
  output logic                                   tx_code_valid_o,
  output logic                                   tx_framed_o,
  output logic                                   remote_loop_o
);

  localparam int NDET = 2;
  localparam int ACT  = 0;
  localparam int DEACT = 1;
  localparam logic [CNT_W-1:0] REPEATS_C = CNT_W'(REPEATS);

  // Reset release through two flip-flops.
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  // Register file and bus slave.
  logic [loop_code_pkg::REG_W-1:0]  len_ctrl_r;
  logic [loop_code_pkg::REG_W-1:0]  len_ctrl_nxt;
  logic [loop_code_pkg::REG_W-1:0]  act_code_r;
  logic [loop_code_pkg::REG_W-1:0]  act_code_nxt;
  logic [loop_code_pkg::REG_W-1:0]  deact_code_r;
  logic [loop_code_pkg::REG_W-1:0]  deact_code_nxt;
  logic [loop_code_pkg::REG_W-1:0]  tx_code_r;
  logic [loop_code_pkg::REG_W-1:0]  tx_code_nxt;
  logic                             ack_r;
  logic                             ack_nxt;
  logic [loop_code_pkg::DATA_W-1:0] rdata_r;
  logic [loop_code_pkg::DATA_W-1:0] rdata_nxt;
  logic [loop_code_pkg::IDX_W-1:0]  idx;
  logic                             req;
  logic                             wr_take;
  logic [loop_code_pkg::REG_W-1:0]  wbyte;
  logic [loop_code_pkg::REG_W-1:0]  status;
  logic [NDET-1:0]                  detected;
  loop_code_pkg::loop_state_t       loop_r;
  loop_code_pkg::loop_state_t       loop_nxt;

  always_comb begin
    status = '0;
    status[loop_code_pkg::STAT_LOOP_BIT]  = (loop_r == loop_code_pkg::LOOP_ACTIVE);
    status[loop_code_pkg::STAT_ACT_BIT]   = detected[ACT];
    status[loop_code_pkg::STAT_DEACT_BIT] = detected[DEACT];
  end

  assign idx = avs_address_i[loop_code_pkg::ADDR_W-1:2];
  assign req = avs_read_i | avs_write_i;
  assign wr_take = avs_write_i & ack_r & avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[loop_code_pkg::REG_W-1:0];

  always_comb begin
    ack_nxt        = req & ~ack_r;
    rdata_nxt      = rdata_r;
    len_ctrl_nxt   = len_ctrl_r;
    act_code_nxt   = act_code_r;
    deact_code_nxt = deact_code_r;
    tx_code_nxt    = tx_code_r;
    if (avs_read_i && !ack_r) begin
      rdata_nxt = '0;
      unique case (idx)
        loop_code_pkg::IDX_LEN_CTRL:
          rdata_nxt[loop_code_pkg::REG_W-1:0] = len_ctrl_r;
        loop_code_pkg::IDX_ACT_CODE:
          rdata_nxt[loop_code_pkg::REG_W-1:0] = act_code_r;
        loop_code_pkg::IDX_DEACT_CODE:
          rdata_nxt[loop_code_pkg::REG_W-1:0] = deact_code_r;
        loop_code_pkg::IDX_STATUS:
          rdata_nxt[loop_code_pkg::REG_W-1:0] = status;
        loop_code_pkg::IDX_TX_CODE:
          rdata_nxt[loop_code_pkg::REG_W-1:0] = tx_code_r;
        default:
          rdata_nxt = '0;
      endcase
    end
    if (wr_take) begin
      unique case (idx)
        loop_code_pkg::IDX_LEN_CTRL:   len_ctrl_nxt   = wbyte;
        loop_code_pkg::IDX_ACT_CODE:   act_code_nxt   = wbyte;
        loop_code_pkg::IDX_DEACT_CODE: deact_code_nxt = wbyte;
        loop_code_pkg::IDX_TX_CODE:    tx_code_nxt    = wbyte;
        default:                       len_ctrl_nxt   = len_ctrl_r;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_r        <= 1'b0;
      rdata_r      <= '0;
      len_ctrl_r   <= loop_code_pkg::LEN_CTRL_RST;
      act_code_r   <= loop_code_pkg::CODE_RST;
      deact_code_r <= loop_code_pkg::CODE_RST;
      tx_code_r    <= loop_code_pkg::CODE_RST;
    end else if (ce_i) begin
      ack_r        <= ack_nxt;
      rdata_r      <= rdata_nxt;
      len_ctrl_r   <= len_ctrl_nxt;
      act_code_r   <= act_code_nxt;
      deact_code_r <= deact_code_nxt;
      tx_code_r    <= tx_code_nxt;
    end
  end

  // A frozen clock enable must not let the master finish an access early.
  assign avs_waitrequest_o = req & ~(ack_r & ce_i);
  assign avs_readdata_o    = rdata_r;

  // Receive detectors, one each for the activation and deactivation code registers.
  logic [loop_code_pkg::CODE_W-1:0] det_code  [NDET];
  logic [loop_code_pkg::SEL_W-1:0]  det_len   [NDET];
  logic [NDET-1:0]                  det_en;

  assign det_code[ACT]   = act_code_r[loop_code_pkg::CODE_HI:loop_code_pkg::CODE_LO];
  assign det_code[DEACT] = deact_code_r[loop_code_pkg::CODE_HI:loop_code_pkg::CODE_LO];
  assign det_len[ACT]    =
    len_ctrl_r[loop_code_pkg::RXA_LEN_HI:loop_code_pkg::RXA_LEN_LO];
  assign det_len[DEACT]  =
    len_ctrl_r[loop_code_pkg::RXD_LEN_HI:loop_code_pkg::RXD_LEN_LO];
  assign det_en[ACT]     = act_code_r[loop_code_pkg::CODE_EN_BIT];
  assign det_en[DEACT]   = deact_code_r[loop_code_pkg::CODE_EN_BIT];

  for (genvar g = 0; g < NDET; g++) begin : g_det
    loop_code_detector #(
      .CNT_W (CNT_W)
    ) u_det (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n),
      .ce_i        (ce_i),
      .enable_i    (det_en[g]),
      .code_i      (det_code[g]),
      .len_sel_i   (det_len[g]),
      .bit_i       (rx_bit_i),
      .bit_valid_i (rx_bit_valid_i),
      .repeats_i   (REPEATS_C),
      .detected_o  (detected[g])
    );
  end

  // Automatic remote loopback.
  logic auto_en;

  assign auto_en = len_ctrl_r[loop_code_pkg::AUTO_BIT];

  always_comb begin
    loop_nxt = loop_r;
    unique case (loop_r)
      loop_code_pkg::LOOP_IDLE: begin
        if (auto_en && det_en[ACT] && detected[ACT]) begin
          loop_nxt = loop_code_pkg::LOOP_ACTIVE;
        end
      end
      loop_code_pkg::LOOP_ACTIVE: begin
        if (auto_en && det_en[DEACT] && detected[DEACT]) begin
          loop_nxt = loop_code_pkg::LOOP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      loop_r <= loop_code_pkg::LOOP_IDLE;
    end else if (ce_i) begin
      loop_r <= loop_nxt;
    end
  end

  assign remote_loop_o = (loop_r == loop_code_pkg::LOOP_ACTIVE);

  // Transmit code generator; the code repeats MSB first.
  logic [loop_code_pkg::LEN_W-1:0]  tx_ptr_r;
  logic [loop_code_pkg::LEN_W-1:0]  tx_ptr_nxt;
  logic                             tx_bit_r;
  logic                             tx_bit_nxt;
  logic [loop_code_pkg::LEN_W-1:0]  tx_len;
  logic [loop_code_pkg::CODE_W-1:0] tx_val;
  logic                             tx_on;
  logic                             framed;
  logic                             tx_step;

  assign tx_len = loop_code_pkg::code_len(
    len_ctrl_r[loop_code_pkg::TX_LEN_HI:loop_code_pkg::TX_LEN_LO]);
  assign tx_val = tx_code_r[loop_code_pkg::CODE_HI:loop_code_pkg::CODE_LO];
  assign tx_on  = tx_code_r[loop_code_pkg::CODE_EN_BIT];
  assign framed = len_ctrl_r[loop_code_pkg::FRAMED_BIT];
  // In framed mode the framing bit slot is left to the framer.
  assign tx_step = ce_i & tx_on & tx_bit_req_i &
                   ~(framed & tx_frame_slot_i);

  always_comb begin
    tx_ptr_nxt = tx_ptr_r;
    if (!tx_on) begin
      tx_ptr_nxt = '0;
    end else if (tx_step) begin
      if (tx_ptr_r >= tx_len - loop_code_pkg::LEN_ONE) begin
        tx_ptr_nxt = '0;
      end else begin
        tx_ptr_nxt = tx_ptr_r + loop_code_pkg::LEN_ONE;
      end
    end
    tx_bit_nxt = tx_val[loop_code_pkg::CODE_MSB - tx_ptr_nxt];
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_ptr_r <= '0;
      tx_bit_r <= 1'b0;
    end else if (ce_i) begin
      tx_ptr_r <= tx_ptr_nxt;
      tx_bit_r <= tx_bit_nxt;
    end
  end

  assign tx_code_bit_o   = tx_bit_r;
  assign tx_code_valid_o = tx_step;
  assign tx_framed_o     = framed;

endmodule : loop_code_control

`default_nettype wire

// ### test/loop_code_control_checker.sv
// Purpose: Port-level checks for the loop code block.
// Assumes: One clock domain; no bus request while reset is held.
// Notes:   Attached to the block by the bind below the module.
`timescale 1ns/1ps
`default_nettype none
module loop_code_control_checker (
  input wire logic                             clock_i,
  input wire logic                             rstn_i,
  input wire logic                             ce_i,
  input wire logic                             avs_read_i,
  input wire logic                             avs_write_i,
  input wire logic [loop_code_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic                             avs_waitrequest_o,
  input wire logic                             rx_bit_valid_i,
  input wire logic                             tx_bit_req_i,
  input wire logic                             tx_frame_slot_i,
  input wire logic                             tx_code_bit_o,
  input wire logic                             tx_code_valid_o,
  input wire logic                             tx_framed_o,
  input wire logic                             remote_loop_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  // Counts cycles since reset so the internal reset release is skipped.
  logic [2:0] up_r;
  logic [2:0] up_nxt;
  always_comb up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i) up_r <= 3'h0;
    else up_r <= up_nxt;
  chk_wait_once: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
    else $error("bus access held past one wait cycle");
  chk_wait_first: assert property ($rose(avs_read_i || avs_write_i)
    |-> avs_waitrequest_o)
    else $error("bus access answered without a wait cycle");
  chk_idle_free: assert property (!(avs_read_i || avs_write_i)
    |-> !avs_waitrequest_o)
    else $error("waitrequest high with no request");
  chk_valid_req: assert property (tx_code_valid_o |-> tx_bit_req_i)
    else $error("code bit consumed without a request");
  chk_slot_skip: assert property (tx_framed_o && tx_frame_slot_i |-> !tx_code_valid_o)
    else $error("code bit sent in a framing slot");
  chk_bit_hold: assert property (up_r == 3'h7 && !tx_code_valid_o &&
    !avs_write_i && !$past(avs_write_i) |=> $stable(tx_code_bit_o))
    else $error("code bit moved without being consumed");
  chk_loop_on: assert property ($rose(remote_loop_o) |-> $past(rx_bit_valid_i, 2))
    else $error("loop entered without a received bit");
  chk_loop_off: assert property ($fell(remote_loop_o) |-> $past(rx_bit_valid_i, 2))
    else $error("loop left without a received bit");
  chk_ce_freeze: assert property (!ce_i |=> $stable(remote_loop_o) &&
    $stable(tx_code_bit_o))
    else $error("state moved while clock enable was low");
endmodule : loop_code_control_checker
bind loop_code_control loop_code_control_checker loop_code_control_checker_inst (
  .clock_i(clock_i),
  .rstn_i(rstn_i),
  .ce_i(ce_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .rx_bit_valid_i(rx_bit_valid_i),
  .tx_bit_req_i(tx_bit_req_i),
  .tx_frame_slot_i(tx_frame_slot_i),
  .tx_code_bit_o(tx_code_bit_o),
  .tx_code_valid_o(tx_code_valid_o),
  .tx_framed_o(tx_framed_o),
  .remote_loop_o(remote_loop_o)
);
`default_nettype wire

// ### test/far_end_terminal.sv
// Purpose: Remote terminal on the line: sends codes, pulls code bits.
// Assumes: Tasks are called just after a rising clock edge.
// Notes:   Line bit toggles when idle so stale values are not seen.
`timescale 1ns/1ps
`default_nettype none
module far_end_terminal (
  input  wire logic clock_i,
  input  wire logic tx_code_bit_i,
  input  wire logic tx_code_valid_i,
  output logic      rx_bit_o,
  output logic      rx_bit_valid_o,
  output logic      tx_bit_req_o,
  output logic      tx_frame_slot_o
);
  logic got_q[$];
  initial begin
    rx_bit_o = 1'b0;
    rx_bit_valid_o = 1'b0;
    tx_bit_req_o = 1'b0;
    tx_frame_slot_o = 1'b0;
  end
  always @(posedge clock_i) begin
    if (tx_code_valid_i === 1'b1) got_q.push_back(tx_code_bit_i);
  end
  // Repeats the first n bits of a code, first bit on top, gap idle cycles apart.
  task automatic send(input logic [6:0] c, input int n, input int reps, input int gap);
    for (int p = 0; p < reps * n; p++) begin
      rx_bit_o <= c[6 - (p % n)];
      rx_bit_valid_o <= 1'b1;
      @(posedge clock_i);
      if (gap > 0) begin
        rx_bit_o <= ~c[6 - (p % n)];
        rx_bit_valid_o <= 1'b0;
        repeat (gap) @(posedge clock_i);
      end
    end
    rx_bit_valid_o <= 1'b0;
    rx_bit_o <= ~rx_bit_o;
  endtask : send
  // Requests k code bits; with slots set every third cycle is a framing slot.
  task automatic pull(input int k, input logic slots);
    int c = 0;
    int taken = 0;
    while (taken < k) begin
      tx_bit_req_o <= 1'b1;
      tx_frame_slot_o <= slots && (c % 3 == 2);
      if (!(slots && (c % 3 == 2))) taken++;
      c++;
      @(posedge clock_i);
    end
    tx_bit_req_o <= 1'b0;
    tx_frame_slot_o <= 1'b0;
  endtask : pull
endmodule : far_end_terminal
`default_nettype wire

// ### test/loop_code_control_tb.sv
// Purpose: Self-checking bench for the loop code block.
// Assumes: Detection needs two code periods (REPEATS set to 2).
// Notes:   Bus accesses are Avalon-MM cycles that wait for waitrequest.
`timescale 1ns/1ps
`default_nettype none
module loop_code_control_tb;
  localparam logic [9:0] LC = loop_code_pkg::IDX_LEN_CTRL;
  localparam logic [9:0] AC = loop_code_pkg::IDX_ACT_CODE;
  localparam logic [9:0] DC = loop_code_pkg::IDX_DEACT_CODE;
  localparam logic [9:0] ST = loop_code_pkg::IDX_STATUS;
  localparam logic [9:0] TX = loop_code_pkg::IDX_TX_CODE;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] code;
    logic       slots;
  } row_t;
  row_t rows [5] = '{'{8'h00, 8'hb5, 1'b0}, '{8'h54, 8'h67, 1'b0},
    '{8'ha8, 8'hcb, 1'b0}, '{8'hfc, 8'h9d, 1'b0}, '{8'hfe, 8'h9d, 1'b1}};
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        ce_i = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        rx_bit, rx_valid, tx_req, tx_slot;
  logic        tx_code_bit_o, tx_code_valid_o, tx_framed_o, remote_loop_o;
  int          n_errors = 0;
  int          total_checks = 0;
  int          n;
  always #10 clock_i = ~clock_i;
  loop_code_control #(.CNT_W(8), .REPEATS(2)) loop_code_control_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_bit_i(rx_bit),
    .rx_bit_valid_i(rx_valid), .tx_bit_req_i(tx_req),
    .tx_frame_slot_i(tx_slot), .tx_code_bit_o(tx_code_bit_o),
    .tx_code_valid_o(tx_code_valid_o), .tx_framed_o(tx_framed_o),
    .remote_loop_o(remote_loop_o));
  far_end_terminal far_end_terminal_inst (
    .clock_i(clock_i), .tx_code_bit_i(tx_code_bit_o),
    .tx_code_valid_i(tx_code_valid_o), .rx_bit_o(rx_bit),
    .rx_bit_valid_o(rx_valid), .tx_bit_req_o(tx_req),
    .tx_frame_slot_o(tx_slot));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk8
  task automatic chk1(input string s, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", s, e, g);
    end
  endtask : chk1
  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(input logic [9:0] idx, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    int t = 0;
    logic busy;
    avs_address <= {idx, 2'b00};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= 32'(d);
    do begin
      @(posedge clock_i);
      t++;
      busy = avs_waitrequest_o;
      q = avs_readdata_o[7:0];
      if (t > 20 && busy !== 1'b0) begin
        chk1("bus answer", 1'b0, busy);
        tally_and_finish();
      end
    end while (busy !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock_i);
  endtask : bus
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(idx, 1'b1, d, x);
  endtask : wr
  task automatic rd(input string s, input logic [9:0] idx, input logic [7:0] e);
    logic [7:0] x;
    bus(idx, 1'b0, 8'h00, x);
    chk8(s, e, x);
  endtask : rd
  task automatic wait_loop(input logic e);
    int t = 0;
    while (remote_loop_o !== e && t < 40) begin
      @(posedge clock_i);
      t++;
    end
    chk1("remote loop", e, remote_loop_o);
    if (remote_loop_o !== e) tally_and_finish();
  endtask : wait_loop
  task automatic no_loop();
    repeat (3) @(posedge clock_i);
    chk1("remote loop", 1'b0, remote_loop_o);
  endtask : no_loop
  initial begin
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd("ctrl reset", LC, 8'h00);
    rd("act reset", AC, 8'haa);
    rd("deact reset", DC, 8'haa);
    rd("status reset", ST, 8'h00);
    for (int r = 0; r < 5; r++) begin
      n = 4 + int'(rows[r].ctrl[3:2]);
      wr(LC, rows[r].ctrl);
      wr(TX, rows[r].code);
      far_end_terminal_inst.got_q.delete();
      far_end_terminal_inst.pull(2 * n, rows[r].slots);
      @(posedge clock_i);
      chk8("tx count", 8'(2 * n), 8'(far_end_terminal_inst.got_q.size()));
      for (int i = 0; i < 2 * n; i++)
        chk1("tx bit", rows[r].code[7 - (i % n)], far_end_terminal_inst.got_q[i]);
      chk1("framed", rows[r].ctrl[1], tx_framed_o);
      rd("ctrl back", LC, rows[r].ctrl);
    end
    // Activation 11001 on five bits, deactivation 0001 on four.
    wr(LC, 8'h40);
    wr(AC, 8'hc9);
    wr(DC, 8'h11);
    far_end_terminal_inst.send(7'h64, 5, 4, 0);
    no_loop();
    wr(AC, 8'hc8);
    wr(LC, 8'h41);
    far_end_terminal_inst.send(7'h64, 5, 4, 0);
    no_loop();
    wr(LC, 8'h01);
    wr(AC, 8'hc9);
    far_end_terminal_inst.send(7'h64, 5, 4, 0);
    no_loop();
    wr(LC, 8'h41);
    far_end_terminal_inst.send(7'h64, 5, 4, 1);
    wait_loop(1'b1);
    rd("status in loop", ST, 8'h03);
    far_end_terminal_inst.send(7'h08, 4, 4, 0);
    wait_loop(1'b0);
    wr(ST, 8'hff);
    rd("status ro", ST, 8'h04);
    rd("unmapped", 10'h000, 8'h00);
    avs_byteenable <= 4'h0;
    wr(LC, 8'hff);
    avs_byteenable <= 4'hf;
    rd("ctrl masked", LC, 8'h41);
    ce_i <= 1'b0;
    far_end_terminal_inst.got_q.delete();
    far_end_terminal_inst.pull(3, 1'b0);
    chk8("tx frozen", 8'h00, 8'(far_end_terminal_inst.got_q.size()));
    ce_i <= 1'b1;
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd("ctrl after reset", LC, 8'h00);
    tally_and_finish();
  end
endmodule : loop_code_control_tb
`default_nettype wire
